/* File: rtl/accr_pkg.sv */
// package: register map, field layout and reset values of the channel config bank
package accr_pkg;
  // printed offsets are not all multiples of four: they are register indices
  localparam logic [7:0]  IDX_OVERSAMPLE  = 8'h27;
  localparam logic [7:0]  IDX_GAIN_RANGE  = 8'h28;
  localparam logic [7:0]  IDX_SLEEP       = 8'h29;
  localparam logic [7:0]  IDX_CH0_SPAN    = 8'h2a;
  localparam int          ADDR_LSB        = 2;
  localparam int          ADDR_W          = 12;
  localparam int          REG_W           = 8;
  localparam int          NUM_CH          = 4;
  localparam int          AVG_EN_BIT      = 7;
  localparam int          CODE_W          = 4;
  localparam logic [7:0]  RST_OVERSAMPLE  = 8'h00;
  localparam logic [7:0]  RST_GAIN_RANGE  = 8'h0f;
  localparam logic [7:0]  RST_SLEEP       = 8'h00;
  localparam logic [7:0]  RST_CH0_SPAN    = 8'h0f;
  localparam logic [7:0]  MASK_OVERSAMPLE = 8'h8f;
  localparam logic [7:0]  MASK_LOW_NIBBLE = 8'h0f;
endpackage

/* File: rtl/accr_reg8.sv */
// one 8-bit configuration register with write mask and reset value
`timescale 1ns/10ps
`default_nettype none
module accr_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hff
) (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  // write port
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wdata_in,
  // value
  output logic      [7:0] q_out
);
  typedef struct packed {
    logic [7:0] val;
  } accr_reg8_s;

  accr_reg8_s st_r;
  accr_reg8_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en_in) begin
      st_nxt.val = wdata_in & WMASK;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_r.val <= RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.val;
endmodule
`default_nettype wire

/* File: rtl/accr_top.sv */
// channel configuration register bank behind an apb slave
// Notes on behaviour
// - bit 7 enables averaging, resets zero
// - ratio code n averages 2^(n+1) results
// - bits 3:0 enable per-channel gain ranging, reset ones
// - sleep bit blocks channel conversion requests
// - channel 0 span code, resets 0xf
// - registers at indices 0x27 to 0x2a
// - upper bits reserved, read-only, zero
`timescale 1ns/10ps
`default_nettype none
module accr_top (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // per-channel conversion requests from the sampling core
  input  wire logic [3:0]  conv_req_in,
  // configuration to the converter core
  output logic             averaging_enable_out,
  output logic      [3:0]  average_count_code_out,
  output logic      [3:0]  auto_gain_ranging_out,
  output logic      [3:0]  power_save_out,
  output logic      [3:0]  ch0_span_code_out,
  output logic             ch0_span_bipolar_out,
  output logic      [3:0]  conv_go_out,
  output logic             ratio_changed_live_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [3:0]  go;
    logic        live_err;
  } accr_state_s;

  accr_state_s st_r;
  accr_state_s st_nxt;

  logic [7:0] os_q;
  logic [7:0] gr_q;
  logic [7:0] sl_q;
  logic [7:0] sp_q;
  logic [7:0] idx;
  logic       aligned;
  logic       hit;
  logic       acc;
  logic       wr;
  logic       lane0;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign idx     = paddr_in[9:2];
  assign aligned = (paddr_in[1:0] == 2'b00) && (paddr_in[11:10] == 2'b00);
  assign hit     = aligned && ((idx == accr_pkg::IDX_OVERSAMPLE) ||
                               (idx == accr_pkg::IDX_GAIN_RANGE) ||
                               (idx == accr_pkg::IDX_SLEEP) ||
                               (idx == accr_pkg::IDX_CH0_SPAN));
  // one wait state: the answer comes in the second access cycle
  assign acc     = psel_in && penable_in && st_r.ready;
  assign wr      = acc && pwrite_in && hit && !st_r.err;
  assign lane0   = pstrb_in[0];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  accr_reg8 #(.RESET_VAL(accr_pkg::RST_OVERSAMPLE), .WMASK(accr_pkg::MASK_OVERSAMPLE)) u_os (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .wr_en_in    (wr && lane0 && idx == accr_pkg::IDX_OVERSAMPLE),
    .wdata_in    (pwdata_in[7:0]),
    .q_out       (os_q)
  );
  accr_reg8 #(.RESET_VAL(accr_pkg::RST_GAIN_RANGE), .WMASK(accr_pkg::MASK_LOW_NIBBLE)) u_gr (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .wr_en_in    (wr && lane0 && idx == accr_pkg::IDX_GAIN_RANGE),
    .wdata_in    (pwdata_in[7:0]),
    .q_out       (gr_q)
  );
  accr_reg8 #(.RESET_VAL(accr_pkg::RST_SLEEP), .WMASK(accr_pkg::MASK_LOW_NIBBLE)) u_sl (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .wr_en_in    (wr && lane0 && idx == accr_pkg::IDX_SLEEP),
    .wdata_in    (pwdata_in[7:0]),
    .q_out       (sl_q)
  );
  accr_reg8 #(.RESET_VAL(accr_pkg::RST_CH0_SPAN), .WMASK(accr_pkg::MASK_LOW_NIBBLE)) u_sp (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .wr_en_in    (wr && lane0 && idx == accr_pkg::IDX_CH0_SPAN),
    .wdata_in    (pwdata_in[7:0]),
    .q_out       (sp_q)
  );

  // ----------------------------------------------------------------
  // bus answer and channel gating
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ready = 1'b0;
    // error flag lives only for the answer cycle so pslverr_out comes straight from a flop
    st_nxt.err   = 1'b0;
    if (psel_in && penable_in && !st_r.ready) begin
      st_nxt.ready = 1'b1;
      st_nxt.err   = !hit;
      st_nxt.rdata = 32'h0000_0000;
      if (hit && !pwrite_in) begin
        case (idx)
          accr_pkg::IDX_OVERSAMPLE: st_nxt.rdata = {24'h00_0000, os_q};
          accr_pkg::IDX_GAIN_RANGE: st_nxt.rdata = {24'h00_0000, gr_q};
          accr_pkg::IDX_SLEEP:      st_nxt.rdata = {24'h00_0000, sl_q};
          accr_pkg::IDX_CH0_SPAN:   st_nxt.rdata = {24'h00_0000, sp_q};
          default:                  st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    // a sleeping channel drops its conversion requests
    st_nxt.go = conv_req_in & ~sl_q[accr_pkg::NUM_CH-1:0];
    // flags a ratio change while averaging stays on; the host should avoid it
    st_nxt.live_err = wr && lane0 && (idx == accr_pkg::IDX_OVERSAMPLE) &&
                      os_q[accr_pkg::AVG_EN_BIT] && pwdata_in[accr_pkg::AVG_EN_BIT] &&
                      (pwdata_in[3:0] != os_q[3:0]);
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // configuration outputs mirror register bits directly; no extra stage to keep them aligned with readback
  assign prdata_out             = st_r.rdata;
  assign pready_out             = st_r.ready;
  assign pslverr_out            = st_r.err;
  assign averaging_enable_out   = os_q[accr_pkg::AVG_EN_BIT];
  assign average_count_code_out = os_q[accr_pkg::CODE_W-1:0];
  assign auto_gain_ranging_out  = gr_q[accr_pkg::NUM_CH-1:0];
  assign power_save_out         = sl_q[accr_pkg::NUM_CH-1:0];
  assign ch0_span_code_out      = sp_q[accr_pkg::CODE_W-1:0];
  assign ch0_span_bipolar_out   = sp_q[0];
  assign conv_go_out            = st_r.go;
  assign ratio_changed_live_out = st_r.live_err;
endmodule
`default_nettype wire

/* File: verif/accr_host.sv */
// host model: apb master that writes and reads the config bank
`timescale 1ns/10ps
`default_nettype none
module accr_host (
  input  wire logic        clk_in, pready_in, pslverr_in,
  input  wire logic [31:0] prdata_in,
  output var  logic        psel_out = 0, penable_out = 0, pwrite_out = 0,
  output var  logic [11:0] paddr_out = '0,
  output var  logic [31:0] pwdata_out = '0
);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk_in);
    {psel_out, pwrite_out, paddr_out, pwdata_out} <= {1'b1, w, a, d};
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    er = pslverr_in;
    // released lines show the inverse so stale values cannot pass
    {psel_out, penable_out, paddr_out, pwdata_out} <= {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* File: verif/accr_properties.sv */
// assertions on the ports of the channel config bank
`timescale 1ns/10ps
`default_nettype none
module accr_properties (
  input wire logic        core_clk_in, srst_in, psel_in, penable_in, pwrite_in,
  input wire logic        pready_out, pslverr_out, averaging_enable_out, ch0_span_bipolar_out,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out,
  input wire logic [3:0]  conv_req_in, conv_go_out, average_count_code_out,
  input wire logic [3:0]  auto_gain_ranging_out, power_save_out, ch0_span_code_out,
  input wire logic [3:0]  pstrb_in,
  input wire logic        ratio_changed_live_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  wire logic wr = pready_out && pwrite_in && !pslverr_out && pstrb_in[0];
  chk_one_wait: assert property ($rose(penable_in) && psel_in |=>
    pready_out ##1 !pready_out) else $error("answer timing wrong");
  chk_unmapped_err: assert property (pready_out |-> pslverr_out ==
    !(paddr_in inside {12'h09c, 12'h0a0, 12'h0a4, 12'h0a8})) else $error("slave error wrong");
  chk_rsvd_zero: assert property (pready_out && !pwrite_in |->
    (prdata_out & ~{24'h0, paddr_in == 12'h09c, 7'h0f}) == 32'h0) else $error("reserved set");
  chk_avg_write: assert property (wr && paddr_in == 12'h09c |=>
    {averaging_enable_out, average_count_code_out} == $past({pwdata_in[7], pwdata_in[3:0]}))
    else $error("oversample field wrong");
  chk_gain_write: assert property (wr && paddr_in == 12'h0a0 |=>
    auto_gain_ranging_out == $past(pwdata_in[3:0])) else $error("gain enables wrong");
  chk_sleep_write: assert property (wr && paddr_in == 12'h0a4 |=>
    power_save_out == $past(pwdata_in[3:0])) else $error("sleep bits wrong");
  chk_span_write: assert property (wr && paddr_in == 12'h0a8 |=>
    ch0_span_code_out == $past(pwdata_in[3:0])) else $error("span code wrong");
  chk_go_gate: assert property (1 |=>
    conv_go_out == ($past(conv_req_in) & ~$past(power_save_out))) else $error("sleep gate wrong");
  chk_span_sign: assert property (ch0_span_bipolar_out == ch0_span_code_out[0])
    else $error("bipolar flag wrong");
  chk_live_flag: assert property (wr && paddr_in == 12'h09c && averaging_enable_out &&
    pwdata_in[7] && pwdata_in[3:0] != average_count_code_out |=> ratio_changed_live_out)
    else $error("live ratio change not flagged");
endmodule
bind accr_top accr_properties i_accr_properties (.*);
`default_nettype wire

/* File: verif/tb_accr_top.sv */
// self-checking bench for the channel config bank
`timescale 1ns/10ps
`default_nettype none
module tb_accr_top;
  logic clk = 0, srst = 1, psel, pen, pwr, prdy, perr, avg, bip, live;
  logic [11:0] pa;
  logic [31:0] pwd, prd;
  logic [3:0]  req = 0, code, gain, slp, span, go;
  logic [3:0]  strb = 4'hf;
  int fail_count = 0, n_compared = 0;
  initial forever #4 clk = ~clk;
  accr_top i_accr_top (.core_clk_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(strb), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .conv_req_in(req), .averaging_enable_out(avg),
    .average_count_code_out(code), .auto_gain_ranging_out(gain), .power_save_out(slp),
    .ch0_span_code_out(span), .ch0_span_bipolar_out(bip), .conv_go_out(go),
    .ratio_changed_live_out(live));
  accr_host i_accr_host (.clk_in(clk), .pready_in(prdy), .pslverr_in(perr), .prdata_in(prd),
    .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(pa), .pwdata_out(pwd));
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d, exp, e);
    logic [31:0] rd;
    logic er;
    i_accr_host.xfer(w, a, d, rd, er);
    if (!w) chk(rd, exp);
    chk(er, e);
  endtask
  task automatic t_reset;
    rw(0, 12'h09c, 0, 32'h00, 0);
    rw(0, 12'h0a0, 0, 32'h0f, 0);
    rw(0, 12'h0a4, 0, 32'h00, 0);
    rw(0, 12'h0a8, 0, 32'h0f, 0);
  endtask
  task automatic t_rsvd;
    rw(1, 12'h0a0, 32'hffff_fff0, 0, 0);
    rw(0, 12'h0a0, 0, 32'h00, 0);
    @(negedge clk);
    chk(gain, 32'h0);
    rw(1, 12'h0ac, 32'hff, 0, 1);
    rw(0, 12'h098, 0, 32'h0, 1);
    strb <= 4'he;
    rw(1, 12'h0a8, 32'h3, 0, 0);
    strb <= 4'hf;
    rw(0, 12'h0a8, 0, 32'h0f, 0);
  endtask
  task automatic t_codes;
    for (int n = 0; n < 16; n++) begin
      rw(1, 12'h09c, n, 0, 0);
      rw(1, 12'h09c, 32'h80 | n, 0, 0);
      rw(1, 12'h0a8, n, 0, 0);
      @(negedge clk);
      chk({live, avg, code, span, bip}, {2'b01, n[3:0], n[3:0], n[0]});
    end
  endtask
  task automatic t_live;
    rw(1, 12'h09c, 32'h81, 0, 0);
    @(negedge clk);
    chk({live, avg, code}, {2'b11, 4'h1});
  endtask
  task automatic t_midreset;
    rw(1, 12'h0a4, 32'hf, 0, 0);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(negedge clk);
    chk({avg, gain, slp, span}, {1'b0, 4'hf, 4'h0, 4'hf});
    rw(0, 12'h0a4, 0, 32'h00, 0);
  endtask
  task automatic t_sleep;
    rw(1, 12'h0a4, 32'h5, 0, 0);
    req <= 4'hf;
    @(posedge clk);
    @(negedge clk);
    chk(go, 32'ha);
    req <= 4'h0;
    rw(0, 12'h0a4, 0, 32'h5, 0);
  endtask
  task automatic print_verdict;
    $display("compared=%0d failed=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    t_reset;
    t_rsvd;
    t_codes;
    t_sleep;
    t_live;
    t_midreset;
    print_verdict;
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
